// ===== common/spep_pkg.sv
`default_nettype none

package spep_pkg;

	// Control codes taken four bits at a time from the data pin.
	localparam logic [3:0] INSTRUCTION_SHIFT_EXECUTE_CODE = 4'h0;
	localparam logic [3:0] READBACK_SHIFT_OUT_CODE        = 4'h1;

	// Last value of the bit counter in each phase of a transaction.
	localparam logic [4:0] CMD_LAST   = 5'h03;
	localparam logic [4:0] INSTR_LAST = 5'h17;
	localparam logic [4:0] IDLE_LAST  = 5'h07;
	localparam logic [4:0] OUT_LAST   = 5'h0f;
	localparam logic [4:0] CNT_ONE    = 5'h01;
	localparam logic [2:0] EXEC_CYCLES = 3'h4;
	localparam logic [2:0] EXEC_ONE    = 3'h1;

	// Nonvolatile control register layout and operation codes.
	localparam int unsigned START_BIT = 15;
	localparam int unsigned ERR_BIT   = 13;
	localparam logic [15:0] OP_BULK_ERASE = 16'h400e;
	localparam logic [15:0] OP_PAGE_ERASE = 16'h4003;
	localparam logic [15:0] OP_DWORD_PROG = 16'h4001;
	localparam logic [15:0] CTRL_RESET    = 16'h0000;
	localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
	localparam logic [7:0]  UNLOCK_SECOND = 8'haa;

	// Programming clock edges each operation needs; plain defaults.
	localparam logic [15:0] BULK_TICKS  = 16'h0040;
	localparam logic [15:0] PAGE_TICKS  = 16'h0020;
	localparam logic [15:0] DWORD_TICKS = 16'h0008;
	localparam logic [15:0] TICK_ONE    = 16'h0001;
	localparam logic [15:0] TICK_NONE   = 16'h0000;

	// Program counter limits; the upper bound is a plain default.
	localparam logic [23:0] PC_SAFE     = 24'h000200;
	localparam logic [23:0] PC_VEC_LAST = 24'h0001ff;
	localparam logic [23:0] PC_IMPL_END = 24'h02b000;
	localparam logic [23:0] PC_STEP     = 24'h000002;

	typedef enum logic [1:0] {
		LK_CMD,
		LK_SIX,
		LK_REG_IDLE,
		LK_REG_OUT
	} spep_link_e;

	typedef enum logic [1:0] {
		KEY_NONE,
		KEY_FIRST,
		KEY_ARMED
	} spep_key_e;

	typedef enum logic [1:0] {
		SEL_CTRL,
		SEL_KEY,
		SEL_READBACK,
		SEL_PC
	} spep_sel_e;

	// Register write from the CPU while it executes a shifted instruction.
	typedef struct packed {
		logic        valid;
		spep_sel_e   sel;
		logic [23:0] data;
	} spep_cpu_wr_s;

	// Instruction handed to the CPU, one-cycle valid.
	typedef struct packed {
		logic        valid;
		logic [23:0] instr;
	} spep_exec_s;

endpackage : spep_pkg

`default_nettype wire

// ===== rtl/spep_sync.sv
`default_nettype none

// Two-stage synchroniser; the first stage feeds only the second.
module spep_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,    // Destination clock.
	input  wire logic         nrst,   // Synchronous reset, active low.
	input  wire logic [W-1:0] d,      // Signal from another domain.
	output var  logic [W-1:0] q       // Synchronised copy.
);

	logic [W-1:0] meta_q;

	// Both stages clear under reset so the output is defined at once.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // spep_sync

`default_nettype wire

// ===== rtl/spep_port.sv
// Functional notes
// RULE_01 - Execute code: CPU suspended for 24 clocks
// RULE_02 - Execute over four clocks while next code shifts
// RULE_03 - Data pin sampled on programming clock rise
// RULE_04 - Programmer sends two-word instructions as two executes
// RULE_05 - Two-cycle instruction finished by a following no-op
// RULE_06 - No stalls; programmer adds no-op before indirection
// RULE_07 - Two-cycle modify then indirect needs two no-ops
// RULE_08 - Counter increments; vector or unimplemented space resets
// RULE_09 - Programmer jumps to safe address periodically
// RULE_10 - Readback: idle 8 clocks, then 16 out
// RULE_11 - Pin input during code, output during readback
// RULE_12 - Keep driving pin until next rising edge
// RULE_13 - Data changes on fall, captured on rise
// RULE_14 - Least significant bit first, both directions
// RULE_15 - Start bit launches operation, hardware clears it
// RULE_16 - Operation advances only on programming clocks
// RULE_17 - Control value selects bulk, page or double-word
// RULE_18 - Start refused without 55h then AAh keys
// RULE_19 - Programmer runs three no-ops after start
// RULE_20 - Programmer polls start bit until clear
// RULE_21 - Code 0000 executes, 0001 reads back, others reserved
// RULE_22 - Programming clock is shift and CPU clock
// RULE_23 - Back to waiting for code after each transaction
`default_nettype none

module spep_port
	import spep_pkg::*;
(
	input  wire logic         core_clk,                 // Core clock.
	input  wire logic         nrst,                     // Sync reset, low.
	input  wire logic         programming_clock_pin,    // Link clock.
	input  wire logic         programming_data_pin_in,  // Pin level.
	output var  logic         programming_data_pin_out, // Pin drive value.
	output var  logic         programming_data_pin_oe,  // Pin drive enable.
	input  wire spep_cpu_wr_s cpu_wr,                   // CPU register write.
	output var  spep_exec_s   exec,                     // Instruction to run.
	output var  logic         cpu_suspend,              // CPU held idle.
	output var  logic [15:0]  nonvolatile_control_register, // Control reg.
	output var  logic [23:0]  program_counter,          // Program counter.
	output var  logic         dev_reset_req,            // Reset request.
	output var  logic         nvm_op_done               // Operation finished.
);

	////////////////////////////////////////////////////////////////////////
	// State records of both domains.

	typedef struct packed {
		spep_link_e  state;
		logic [4:0]  cnt;
		logic [3:0]  cmd;
		logic [23:0] instr;
		logic [15:0] shreg;
		logic        oe;
		logic [2:0]  exec_left;
		logic        instr_tgl;
		logic        tick_tgl;
		logic        req_tgl;
	} spep_link_s;

	typedef struct packed {
		spep_exec_s  exec;
		logic [15:0] ctrl;
		logic [15:0] readback;
		logic [15:0] snap;
		logic [23:0] pc;
		spep_key_e   key;
		logic [15:0] ticks_left;
		logic        suspend;
		logic        dev_reset;
		logic        op_done;
		logic        instr_seen;
		logic        tick_seen;
		logic        req_seen;
	} spep_core_s;

	spep_link_s link_q;
	spep_link_s link_d;
	spep_core_s core_q;
	spep_core_s core_d;
	logic       link_nrst;
	logic       out_bit_q;
	logic [3:0] link_sy;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Ticks an operation needs; zero marks a code that is not accepted.
	function automatic logic [15:0] op_ticks(input logic [15:0] op);
		logic [15:0] t;
		logic [15:0] code;
		// The start bit rides along with the code but is not part of it.
		code            = op;
		code[START_BIT] = 1'b0;
		t               = TICK_NONE;
		case (code)
			OP_BULK_ERASE: t = BULK_TICKS;  // [RULE_17]
			OP_PAGE_ERASE: t = PAGE_TICKS;  // [RULE_17]
			OP_DWORD_PROG: t = DWORD_TICKS; // [RULE_17]
			default:       t = TICK_NONE;
		endcase
		return t;
	endfunction

	// Vector space and unimplemented space both count as invalid.
	function automatic logic pc_invalid(input logic [23:0] pc);
		return (pc <= PC_VEC_LAST) || (pc >= PC_IMPL_END); // [RULE_08]
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link domain, clocked by the programming clock pin.

	// The reset reaches the link only while its clock runs.
	spep_sync #(.W(1)) u_link_rst (
		.clk  (programming_clock_pin), // [RULE_22]
		.nrst (1'b1),
		.d    (nrst),
		.q    (link_nrst)
	);

	// Serial engine: one bit per rising edge, least significant first.
	always_comb begin
		link_d = link_q;
		link_d.tick_tgl = ~link_q.tick_tgl; // [RULE_16]
		if (link_q.exec_left != 3'h0) begin
			link_d.exec_left = link_q.exec_left - EXEC_ONE; // [RULE_02]
		end
		case (link_q.state)
			LK_CMD: begin
				// Next code shifts while the last instruction runs.
				link_d.cmd = {programming_data_pin_in,
					link_q.cmd[3:1]}; // [RULE_03] [RULE_14] [RULE_02]
				link_d.cnt = link_q.cnt + CNT_ONE;
				if (link_q.cnt == CMD_LAST) begin
					link_d.cnt = '0;
					case (link_d.cmd)
						INSTRUCTION_SHIFT_EXECUTE_CODE: begin
							link_d.state = LK_SIX; // [RULE_21]
						end
						READBACK_SHIFT_OUT_CODE: begin
							link_d.state   = LK_REG_IDLE; // [RULE_21]
							link_d.req_tgl = ~link_q.req_tgl;
						end
						default: begin
							link_d.state = LK_CMD; // [RULE_21]
						end
					endcase
				end
			end
			LK_SIX: begin
				link_d.instr = {programming_data_pin_in,
					link_q.instr[23:1]}; // [RULE_01] [RULE_14]
				link_d.cnt = link_q.cnt + CNT_ONE;
				if (link_q.cnt == INSTR_LAST) begin
					link_d.cnt       = '0;
					link_d.state     = LK_CMD; // [RULE_23]
					link_d.instr_tgl = ~link_q.instr_tgl;
					link_d.exec_left = EXEC_CYCLES; // [RULE_02]
				end
			end
			LK_REG_IDLE: begin
				// The pin stays an input while the CPU idles.
				link_d.cnt = link_q.cnt + CNT_ONE;
				if (link_q.cnt == IDLE_LAST) begin
					link_d.cnt   = '0;
					link_d.state = LK_REG_OUT; // [RULE_10]
					link_d.shreg = core_q.snap;
					link_d.oe    = 1'b1; // [RULE_11]
				end
			end
			LK_REG_OUT: begin
				link_d.shreg = {1'b0, link_q.shreg[15:1]}; // [RULE_14]
				link_d.cnt   = link_q.cnt + CNT_ONE;
				if (link_q.cnt == OUT_LAST) begin
					// Drive ends on the rise that takes the last bit.
					link_d.cnt   = '0;
					link_d.state = LK_CMD; // [RULE_23]
					link_d.oe    = 1'b0; // [RULE_12]
				end
			end
			default: begin
				link_d.state = LK_CMD;
				link_d.cnt   = '0;
			end
		endcase
	end

	// Link state register.
	always_ff @(posedge programming_clock_pin) begin
		if (!link_nrst) begin
			link_q <= '{state: LK_CMD, default: '0};
		end else begin
			link_q <= link_d;
		end
	end

	// Outgoing bits change on the falling edge, away from the capture.
	always_ff @(negedge programming_clock_pin) begin
		if (!link_nrst) begin
			out_bit_q <= 1'b0;
		end else begin
			out_bit_q <= link_q.shreg[0]; // [RULE_13]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossing into the core domain.

	// Toggles mark events; the instruction word is held still for at least
	// four link clocks after its toggle, far longer than the sync delay.
	spep_sync #(.W(4)) u_core_sync (
		.clk  (core_clk),
		.nrst (nrst),
		.d    ({link_q.instr_tgl, link_q.tick_tgl, link_q.req_tgl,
			link_q.exec_left != 3'h0}),
		.q    (link_sy)
	);

	////////////////////////////////////////////////////////////////////////
	// Core domain: instruction hand-off, counter and nonvolatile control.

	always_comb begin
		core_d = core_q;
		core_d.exec.valid = 1'b0;
		core_d.dev_reset  = 1'b0;
		core_d.op_done    = 1'b0;
		// CPU runs only in the four clocks after a shifted instruction.
		core_d.suspend = ~link_sy[0]; // [RULE_01] [RULE_10]

		// New instruction: hand it over and advance the counter.
		if (link_sy[3] != core_q.instr_seen) begin
			core_d.instr_seen = link_sy[3];
			// No stall is inserted, so a two-cycle instruction only
			// finishes on the clocks of the execute that follows it.
			core_d.exec.valid = 1'b1; // [RULE_02] [RULE_05] [RULE_06]
			core_d.exec.instr = link_q.instr;
			core_d.pc = core_q.pc + PC_STEP; // [RULE_08]
			if (pc_invalid(core_d.pc)) begin
				core_d.dev_reset = 1'b1; // [RULE_08]
				core_d.pc        = PC_SAFE;
			end
		end

		// The operation only counts programming clock edges.
		if (link_sy[2] != core_q.tick_seen) begin
			core_d.tick_seen = link_sy[2];
			if (core_q.ctrl[START_BIT]) begin
				core_d.ticks_left = core_q.ticks_left - TICK_ONE; // [RULE_16]
				if (core_q.ticks_left == TICK_ONE) begin
					core_d.ctrl[START_BIT] = 1'b0; // [RULE_15]
					core_d.op_done = 1'b1;
				end
			end
		end

		// Readback request: freeze a snapshot for the link to load.
		if (link_sy[1] != core_q.req_seen) begin
			core_d.req_seen = link_sy[1];
			core_d.snap     = core_q.readback; // [RULE_10]
		end

		// CPU writes; any write other than the key breaks the unlock.
		if (cpu_wr.valid) begin
			if (cpu_wr.sel != SEL_KEY) begin
				core_d.key = KEY_NONE; // [RULE_18]
			end
			case (cpu_wr.sel)
				SEL_CTRL: begin
					// Ignored while busy so a running operation keeps
					// its code; a finish in this cycle is seen first.
					if (!core_d.ctrl[START_BIT]) begin
						core_d.ctrl = cpu_wr.data[15:0];
						core_d.ctrl[START_BIT] = 1'b0;
						if (cpu_wr.data[START_BIT]) begin
							if (core_q.key == KEY_ARMED &&
								op_ticks(cpu_wr.data[15:0]) != TICK_NONE) begin
								core_d.ctrl[START_BIT] = 1'b1; // [RULE_15]
								core_d.ctrl[ERR_BIT]   = 1'b0;
								core_d.ticks_left =
									op_ticks(cpu_wr.data[15:0]); // [RULE_17]
							end else begin
								core_d.ctrl[ERR_BIT] = 1'b1; // [RULE_18]
							end
						end
					end
				end
				SEL_KEY: begin
					if (cpu_wr.data[7:0] == UNLOCK_FIRST) begin
						core_d.key = KEY_FIRST; // [RULE_18]
					end else if (cpu_wr.data[7:0] == UNLOCK_SECOND &&
						core_q.key == KEY_FIRST) begin
						core_d.key = KEY_ARMED; // [RULE_18]
					end else begin
						core_d.key = KEY_NONE;
					end
				end
				SEL_READBACK: begin
					core_d.readback = cpu_wr.data[15:0];
				end
				SEL_PC: begin
					core_d.pc = cpu_wr.data; // [RULE_09]
				end
				default: begin
					core_d.readback = core_q.readback;
				end
			endcase
		end
	end

	// Core state register.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			core_q <= '{ctrl: CTRL_RESET, pc: PC_SAFE, key: KEY_NONE,
				suspend: 1'b1, default: '0};
		end else begin
			core_q <= core_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop.

	assign programming_data_pin_out     = out_bit_q; // [RULE_13]
	assign programming_data_pin_oe      = link_q.oe; // [RULE_11]
	assign exec                         = core_q.exec;
	assign cpu_suspend                  = core_q.suspend;
	assign nonvolatile_control_register = core_q.ctrl;
	assign program_counter              = core_q.pc;
	assign dev_reset_req                = core_q.dev_reset;
	assign nvm_op_done                  = core_q.op_done;

endmodule // spep_port

`default_nettype wire

// ===== testbench/spep_port_sva.sv
`default_nettype none

module spep_port_sva
	import spep_pkg::*;
(
	input wire logic         core_clk,                     // Core clock.
	input wire logic         nrst,                         // Reset, low.
	input wire logic         programming_clock_pin,        // Link clock.
	input wire logic         programming_data_pin_in,      // Pin level.
	input wire logic         programming_data_pin_out,     // Pin value.
	input wire logic         programming_data_pin_oe,      // Pin enable.
	input wire spep_cpu_wr_s cpu_wr,                       // CPU write.
	input wire spep_exec_s   exec,                         // Instruction.
	input wire logic         cpu_suspend,                  // CPU idle.
	input wire logic [15:0]  nonvolatile_control_register, // Control.
	input wire logic [23:0]  program_counter,              // Counter.
	input wire logic         dev_reset_req,                // Reset pulse.
	input wire logic         nvm_op_done                   // Done pulse.
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] key_q;
	logic [3:0] idle_q;
	logic       pin_q;
	logic       pcwr_q;
	logic       code_ok;
	logic       start;

	// A start only counts while no operation runs, since those are ignored.
	assign start = cpu_wr.valid && cpu_wr.sel == SEL_CTRL &&
		cpu_wr.data[START_BIT] && !nonvolatile_control_register[START_BIT];
	assign code_ok = cpu_wr.data[14:0] inside {OP_BULK_ERASE[14:0],
		OP_PAGE_ERASE[14:0], OP_DWORD_PROG[14:0]};

	// Any write in between spoils the unlock pair, so any write but a 55h key or an AAh key after it resets it.
	always_ff @(posedge core_clk) begin
		pin_q  <= programming_clock_pin;
		pcwr_q <= cpu_wr.valid && cpu_wr.sel == SEL_PC;
		if (!nrst || pin_q != programming_clock_pin)
			idle_q <= 4'h0;
		else if (idle_q != 4'hf)
			idle_q <= idle_q + 4'h1;
		if (!nrst)
			key_q <= 2'h0;
		else if (cpu_wr.valid && cpu_wr.sel == SEL_KEY &&
			cpu_wr.data[7:0] == UNLOCK_FIRST)
			key_q <= 2'h1;
		else if (cpu_wr.valid)
			key_q <= (cpu_wr.sel == SEL_KEY && key_q == 2'h1 &&
				cpu_wr.data[7:0] == UNLOCK_SECOND) ? 2'h2 : 2'h0;
	end

	////////////////////////////////////////////////////////////////
	property p_exec_pulse;
		@(posedge core_clk) disable iff (!nrst) exec.valid |=> !exec.valid;
	endproperty
	a_exec_pulse: assert property (p_exec_pulse) else $error("exec long");
	property p_exec_window;
		@(posedge core_clk) disable iff (!nrst)
		exec.valid |-> ##[0:16] !cpu_suspend;
	endproperty
	a_exec_window: assert property (p_exec_window) else $error("no window");
	property p_start_ok;
		@(posedge core_clk) disable iff (!nrst) start && key_q == 2'h2 &&
		code_ok |=> nonvolatile_control_register[START_BIT] &&
		!nonvolatile_control_register[ERR_BIT];
	endproperty
	a_start_ok: assert property (p_start_ok) else $error("no start");
	property p_start_refused;
		@(posedge core_clk) disable iff (!nrst)
		start && !(key_q == 2'h2 && code_ok) |=>
		!nonvolatile_control_register[START_BIT] &&
		nonvolatile_control_register[ERR_BIT];
	endproperty
	a_start_refused: assert property (p_start_refused) else $error("bad start");
	property p_done;
		@(posedge core_clk) disable iff (!nrst)
		$fell(nonvolatile_control_register[START_BIT]) |-> nvm_op_done;
	endproperty
	a_done: assert property (p_done) else $error("no done pulse");
	property p_hold;
		@(posedge core_clk) disable iff (!nrst)
		$past(nonvolatile_control_register[START_BIT]) && idle_q == 4'hf
		|-> nonvolatile_control_register[START_BIT];
	endproperty
	a_hold: assert property (p_hold) else $error("ran without clock");
	property p_count;
		@(posedge core_clk) disable iff (!nrst)
		$changed(program_counter) && !pcwr_q |-> program_counter == PC_SAFE
		|| program_counter == $past(program_counter) + PC_STEP;
	endproperty
	a_count: assert property (p_count) else $error("bad step");
	property p_reload;
		@(posedge core_clk) disable iff (!nrst)
		dev_reset_req |-> ##[0:1] program_counter == PC_SAFE;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_out_fall;
		@(posedge core_clk) disable iff (!nrst)
		$changed(programming_data_pin_out) |-> !programming_clock_pin;
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("out on rise");
	property p_oe_len;
		@(posedge programming_clock_pin) disable iff (!nrst)
		$rose(programming_data_pin_oe) |-> programming_data_pin_oe[*8]
		##1 programming_data_pin_oe[*8] ##1 !programming_data_pin_oe;
	endproperty
	a_oe_len: assert property (p_oe_len) else $error("drive length");

	c_exec: cover property (@(posedge core_clk) exec.valid);
	c_done: cover property (@(posedge core_clk) nvm_op_done);
	c_reset: cover property (@(posedge core_clk) dev_reset_req);
endmodule // spep_port_sva

`default_nettype wire

// ===== testbench/spep_prog_model.sv
`default_nettype none

module spep_prog_model (
	output var  logic prog_clk, // Link clock.
	output var  logic prog_d,   // Driven data.
	output var  logic prog_en,  // Programmer drives.
	input  wire logic pin       // Resolved pin.
);
	timeunit 1ns;
	timeprecision 100ps;

	// The link clock stands still between frames.
	initial begin
		prog_clk = 1'b0;
		prog_d   = 1'b0;
		prog_en  = 1'b1;
	end

	// Data moves while the clock is low; the pin is read at the rise.
	task automatic tick(input logic b, output logic s);
		prog_d = b;
		#62.5 s = pin;
		prog_clk = 1'b1;
		#62.5 prog_clk = 1'b0;
	endtask

	task automatic shift(input int n, input logic [23:0] v);
		logic s;
		for (int i = 0; i < n; i++)
			tick(v[i], s);
	endtask

	// The pin is let go for idle and output phases to avoid a clash.
	task automatic readback_shift_out_code(output logic [15:0] r);
		logic s;
		shift(4, 24'h000001);
		prog_en = 1'b0;
		for (int i = 0; i < 24; i++) begin
			tick(prog_d, s);
			if (i >= 8)
				r[i-8] = s;
		end
		prog_en = 1'b1;
	endtask
endmodule // spep_prog_model

`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none

module tb;
	import spep_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic         core_clk, nrst, pclk, pd, pen, pin, d_out, d_oe;
	logic         susp, rst_req, done;
	spep_cpu_wr_s cpu_wr;
	spep_exec_s   exec;
	logic [15:0]  ctrl;
	logic [23:0]  prog_cnt;
	logic [23:0]  got_q[$];
	int           fails, n_compared, n_rst, n_done;

	// Both driving gives an unknown; nobody driving gives the inverse of the programmer's data.
	assign pin = (d_oe && pen) ? 1'bx : d_oe ? d_out : pen ? pd : ~pd;

	spep_port i_dut (.core_clk(core_clk), .nrst(nrst),
		.programming_clock_pin(pclk), .programming_data_pin_in(pin),
		.programming_data_pin_out(d_out), .programming_data_pin_oe(d_oe),
		.cpu_wr(cpu_wr), .exec(exec), .cpu_suspend(susp),
		.nonvolatile_control_register(ctrl), .program_counter(prog_cnt),
		.dev_reset_req(rst_req), .nvm_op_done(done));
	spep_prog_model i_prog (.prog_clk(pclk), .prog_d(pd), .prog_en(pen),
		.pin(pin));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Pulses are counted here so that no one-cycle output is missed.
	always @(negedge core_clk) begin
		if (exec.valid === 1'b1)
			got_q.push_back(exec.instr);
		if (rst_req === 1'b1)
			n_rst++;
		if (done === 1'b1)
			n_done++;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [23:0] e, logic [23:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wr(spep_sel_e s, logic [23:0] d);
		@(negedge core_clk);
		cpu_wr = '{1'b1, s, d};
		@(negedge core_clk);
		cpu_wr.valid = 1'b0;
	endtask

	task automatic exec_instr(logic [23:0] v);
		i_prog.shift(4, 24'h000000);
		i_prog.shift(24, v);
	endtask

	task automatic t_readback(logic [15:0] v);
		logic [15:0] r;
		wr(SEL_READBACK, {8'h00, v});
		i_prog.readback_shift_out_code(r);
		chk("readback", {8'h00, v}, {8'h00, r});
	endtask

	task automatic t_reserved();
		for (int c = 2; c < 16; c++)
			i_prog.shift(4, 24'(c));
		t_readback(16'h3c96);
	endtask

	task automatic t_exec();
		logic [23:0] p0;
		logic [15:0] r;
		p0 = prog_cnt;
		got_q.delete();
		exec_instr(24'h5a0f3c);
		exec_instr(24'h00a5a5);
		exec_instr(24'h000000);
		exec_instr(24'h000000);
		i_prog.readback_shift_out_code(r);
		chk("exec count", 24'h000004, 24'(got_q.size()));
		chk("instr", 24'h5a0f3c, got_q[0]);
		chk("second word", 24'h00a5a5, got_q[1]);
		chk("counter", p0 + 24'h000008, prog_cnt);
	endtask

	task automatic t_bad_count(logic [23:0] start);
		int n0;
		n0 = n_rst;
		wr(SEL_PC, start);
		exec_instr(24'h000000);
		i_prog.shift(4, 24'h00000f);
		chk("reset pulses", 24'h000001, 24'(n_rst - n0));
		chk("reload", PC_SAFE, prog_cnt);
	endtask

	task automatic t_nvm(logic [15:0] op, logic keys, logic ok);
		logic [15:0] r;
		int n0;
		n0 = n_done;
		if (keys)
			wr(SEL_KEY, {16'h0000, UNLOCK_FIRST});
		wr(SEL_KEY, {16'h0000, UNLOCK_SECOND});
		wr(SEL_CTRL, {8'h00, op | 16'h8000});
		chk("start", {23'h0, ok}, {23'h0, ctrl[START_BIT]});
		chk("error", {23'h0, !ok}, {23'h0, ctrl[ERR_BIT]});
		repeat (40) @(negedge core_clk);
		chk("held", {23'h0, ok}, {23'h0, ctrl[START_BIT]});
		// Three no-ops follow the start before anything else is sent.
		for (int i = 0; i < 3; i++)
			exec_instr(24'h000000);
		for (int i = 0; i < 4 && ctrl[START_BIT] !== 1'b0; i++)
			i_prog.readback_shift_out_code(r);
		chk("cleared", 24'h000000, {23'h0, ctrl[START_BIT]});
		chk("done", {23'h0, ok}, 24'(n_done - n0));
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// The link side needs its own clock edges to leave reset.
	initial begin
		cpu_wr = '0;
		nrst = 1'b0;
		fails = 0;
		n_compared = 0;
		n_rst = 0;
		n_done = 0;
		fork
			i_prog.shift(4, 24'h000000);
			repeat (20) @(negedge core_clk);
		join
		@(negedge core_clk);
		nrst = 1'b1;
		// The link leaves reset on the second rise; the third takes a bit.
		i_prog.shift(2, 24'h000000);
		t_readback(16'ha5c3);
		t_reserved();
		t_exec();
		t_bad_count(24'h02affe);
		t_bad_count(24'h0001fc);
		t_nvm(OP_BULK_ERASE, 1'b1, 1'b1);
		t_nvm(OP_PAGE_ERASE, 1'b1, 1'b1);
		t_nvm(OP_DWORD_PROG, 1'b1, 1'b1);
		t_nvm(16'h4002, 1'b1, 1'b0);
		t_nvm(OP_DWORD_PROG, 1'b0, 1'b0);
		give_verdict();
	end
endmodule // tb

bind spep_port spep_port_sva i_sva (
	.core_clk                     (core_clk),
	.nrst                         (nrst),
	.programming_clock_pin        (programming_clock_pin),
	.programming_data_pin_in      (programming_data_pin_in),
	.programming_data_pin_out     (programming_data_pin_out),
	.programming_data_pin_oe      (programming_data_pin_oe),
	.cpu_wr                       (cpu_wr),
	.exec                         (exec),
	.cpu_suspend                  (cpu_suspend),
	.nonvolatile_control_register (nonvolatile_control_register),
	.program_counter              (program_counter),
	.dev_reset_req                (dev_reset_req),
	.nvm_op_done                  (nvm_op_done)
);

`default_nettype wire
